// [adzpc_pkg.sv]
// constants for the analog dead-zone position compensation block
package adzpc_pkg;
    localparam logic [15:0] ADZPC_IDX_DEADZONE = 16'h4316;
    localparam logic [7:0] ADZPC_SUB_COUNT = 8'h00;
    localparam logic [7:0] ADZPC_SUB_DEADZONE = 8'h01;
    localparam logic [7:0] ADZPC_ENTRY_COUNT = 8'h01;
    localparam logic [15:0] ADZPC_DEADZONE_RST = 16'h0000;
    localparam logic signed [31:0] ADZPC_FS_LSB = 32'sh00006CF0;
    localparam logic signed [31:0] ADZPC_FS_MV = 32'sh00002710;
    localparam int ADZPC_W = 32;
endpackage : adzpc_pkg

// [adzpc_core.sv]
// dead-zone conditioning and bounded compensation integral for the analog channel
// Summary of operation
// - while the input has moved no more than the threshold, the output holds its last value.
// - once the move exceeds the threshold, the output takes the present input value.
// - the dead zone acts only with compensation enabled; otherwise the input passes through.
// - the threshold is a 16-bit writable object in millivolts, 0 to 65535.
// - the offset is taken in converter LSBs, where 27888 LSB equal 10000 mV.
// - the internal offset is taken directly in millivolts with no scaling.
// - the compensation integral is in command units and bounded by the integration limit.
// - with compensation on, the position demand is target plus offset plus compensation.
`timescale 1ns/1ps
module adzpc_core
    import adzpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic signed [15:0] first_analog_channel,
    input wire logic signed [15:0] offset_lsb,
    input wire logic signed [15:0] internal_offset_mv,
    input wire logic comp_enable,
    input wire logic [30:0] integ_limit,
    input wire logic signed [31:0] target_pos,
    input wire logic signed [31:0] pos_offset,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_subindex,
    input wire logic [15:0] obj_wdata,
    output logic [15:0] obj_rdata,
    output logic obj_err,
    output logic signed [31:0] vin_mv,
    output logic vin_valid,
    output logic signed [31:0] dz_out,
    output logic dz_valid,
    output logic signed [31:0] comp_value,
    output logic signed [31:0] pos_demand
);
    import adzpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // object access

    logic [15:0] deadzone;
    logic [15:0] next_deadzone;
    logic [15:0] next_obj_rdata;
    logic next_obj_err;
    logic hit_count;
    logic hit_dz;

    always_comb begin
        hit_count = (obj_index == ADZPC_IDX_DEADZONE) && (obj_subindex == ADZPC_SUB_COUNT);
        hit_dz = (obj_index == ADZPC_IDX_DEADZONE) && (obj_subindex == ADZPC_SUB_DEADZONE);
        next_deadzone = deadzone;
        next_obj_rdata = obj_rdata;
        next_obj_err = 1'b0;
        if (obj_wr) begin
            if (hit_dz) begin
                next_deadzone = obj_wdata;
            end else begin
                next_obj_err = 1'b1;
            end
        end else if (obj_rd) begin
            if (hit_count) begin
                next_obj_rdata = {8'h00, ADZPC_ENTRY_COUNT};
            end else if (hit_dz) begin
                next_obj_rdata = deadzone;
            end else begin
                next_obj_rdata = 16'h0000;
                next_obj_err = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            deadzone <= ADZPC_DEADZONE_RST;
            obj_rdata <= 16'h0000;
            obj_err <= 1'b0;
        end else begin
            deadzone <= next_deadzone;
            obj_rdata <= next_obj_rdata;
            obj_err <= next_obj_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // voltage scaling, dead zone, integral

    logic signed [31:0] lsb_corr;
    logic signed [31:0] scaled;
    logic signed [31:0] next_vin_mv;
    logic signed [32:0] delta;
    logic [32:0] abs_delta;
    logic dz_active;
    logic signed [31:0] next_dz_out;
    logic next_dz_valid;
    logic signed [32:0] integ_sum;
    logic signed [32:0] lim;
    logic signed [31:0] next_comp_value;
    logic signed [31:0] next_pos_demand;

    always_comb begin
        lsb_corr = 32'(first_analog_channel) - 32'(offset_lsb);
        scaled = (lsb_corr * ADZPC_FS_MV) / ADZPC_FS_LSB;
        next_vin_mv = vin_mv;
        if (sample_valid) begin
            next_vin_mv = scaled - 32'(internal_offset_mv);
        end
        delta = 33'(vin_mv) - 33'(dz_out);
        abs_delta = delta[32] ? 33'(-delta) : 33'(delta);
        dz_active = comp_enable && (deadzone != 16'h0000);
        next_dz_out = dz_out;
        if (vin_valid) begin
            if (!dz_active || (abs_delta > 33'(deadzone))) begin
                next_dz_out = vin_mv;
            end
        end
        next_dz_valid = vin_valid;
        lim = 33'(integ_limit);
        integ_sum = 33'(comp_value) + 33'(dz_out);
        next_comp_value = comp_value;
        if (!comp_enable) begin
            next_comp_value = 32'sh00000000;
        end else if (dz_valid) begin
            if (integ_sum > lim) begin
                next_comp_value = lim[31:0];
            end else if (integ_sum < -lim) begin
                next_comp_value = 32'(-lim);
            end else begin
                next_comp_value = integ_sum[31:0];
            end
        end
        next_pos_demand = target_pos + pos_offset + (comp_enable ? comp_value : 32'sh00000000);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vin_mv <= 32'sh00000000;
            vin_valid <= 1'b0;
            dz_out <= 32'sh00000000;
            dz_valid <= 1'b0;
            comp_value <= 32'sh00000000;
            pos_demand <= 32'sh00000000;
        end else begin
            vin_mv <= next_vin_mv;
            vin_valid <= sample_valid;
            dz_out <= next_dz_out;
            dz_valid <= next_dz_valid;
            comp_value <= next_comp_value;
            pos_demand <= next_pos_demand;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_hold;
        vin_valid && dz_active && (abs_delta <= 33'(deadzone)) |=> $stable(dz_out);
    endproperty
    a_hold: assert property (p_hold) else $error("dead-zone output moved inside band");

    property p_jump;
        vin_valid && dz_active && (abs_delta > 33'(deadzone)) |=> dz_out == $past(vin_mv);
    endproperty
    a_jump: assert property (p_jump) else $error("output did not take input");

    property p_pass;
        vin_valid && !comp_enable |=> dz_out == $past(vin_mv);
    endproperty
    a_pass: assert property (p_pass) else $error("no pass-through while disabled");

    property p_zero;
        vin_valid && (deadzone == 16'h0000) |=> dz_out == $past(vin_mv);
    endproperty
    a_zero: assert property (p_zero) else $error("zero threshold did not follow");

    property p_wr;
        obj_wr && hit_dz |=> deadzone == $past(obj_wdata) && !obj_err;
    endproperty
    a_wr: assert property (p_wr) else $error("threshold write lost");

    property p_refuse;
        obj_wr && !hit_dz |=> obj_err && (deadzone == $past(deadzone));
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused write not flagged");

    property p_rdback;
        obj_rd && !obj_wr && hit_dz |=> obj_rdata == $past(deadzone);
    endproperty
    a_rdback: assert property (p_rdback) else $error("threshold read back wrong");

    property p_scale;
        sample_valid && (lsb_corr == ADZPC_FS_LSB) && (internal_offset_mv == 16'sh0000)
            |=> vin_mv == ADZPC_FS_MV;
    endproperty
    a_scale: assert property (p_scale) else $error("full scale not 10000 mV");

    property p_cycle;
        sample_valid |=> vin_valid ##1 dz_valid;
    endproperty
    a_cycle: assert property (p_cycle) else $error("sample not compared next cycle");

    property p_bound;
        comp_enable |-> (33'(comp_value) <= lim) && (33'(comp_value) >= -lim);
    endproperty
    a_bound: assert property (p_bound) else $error("integral outside limit");

    property p_demand;
        !comp_enable ##1 !comp_enable |-> pos_demand == $past(target_pos) + $past(pos_offset);
    endproperty
    a_demand: assert property (p_demand) else $error("demand off while disabled");

    c_hold: cover property (vin_valid && dz_active && abs_delta <= 33'(deadzone));
    c_jump: cover property (vin_valid && dz_active && abs_delta > 33'(deadzone));
    c_clamp: cover property (comp_enable && dz_valid && integ_sum > lim);
    c_bad_obj: cover property (obj_err);

endmodule : adzpc_core

// [adzpc_host.sv]
// host controller model driving the object port
`timescale 1ns/1ps
module adzpc_host (
    input wire logic core_clk,
    input wire logic [15:0] obj_rdata,
    input wire logic obj_err,
    output logic obj_wr,
    output logic obj_rd,
    output logic [15:0] obj_index,
    output logic [7:0] obj_subindex,
    output logic [15:0] obj_wdata
);
    initial begin
        {obj_wr, obj_rd, obj_index, obj_subindex, obj_wdata} = '0;
    end
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
            input logic [15:0] d, output logic [15:0] r, output logic x);
        @(negedge core_clk);
        obj_wr = w;
        obj_rd = !w;
        obj_index = i;
        obj_subindex = s;
        obj_wdata = d;
        @(negedge core_clk);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_wdata = ~d;
        r = obj_rdata;
        x = obj_err;
    endtask : xfer
endmodule : adzpc_host

// [adzpc_core_bench.sv]
// self-checking bench for the dead-zone compensation block
`timescale 1ns/1ps
module adzpc_core_bench;
    import adzpc_pkg::*;
    localparam int LIMIT = 500 * 12 / 10; // 1.2 times the travel needed
    localparam logic [23:0] A_CNT = {ADZPC_IDX_DEADZONE, ADZPC_SUB_COUNT};
    localparam logic [23:0] A_DZ = {ADZPC_IDX_DEADZONE, ADZPC_SUB_DEADZONE};
    logic core_clk = 1'b0, nrst = 1'b0, sv = 1'b0, en = 1'b0, wr, rd, err, vv, dv, e;
    logic signed [15:0] code = '0, off = '0, ioff = '0;
    logic [30:0] lim = 31'h7FFFFFFF;
    logic signed [31:0] tgt = 32'sh000003E8, poff = 32'sh00000018, vin, dz, cv, pd;
    logic [15:0] idx, wd, rdat, rv;
    logic [7:0] sub;
    int miscompares = 0, num_checks = 0, dz_m = 0, thr = 0;
    always #50 core_clk = ~core_clk;
    adzpc_core dut_u (.core_clk(core_clk), .nrst(nrst), .sample_valid(sv),
        .first_analog_channel(code), .offset_lsb(off), .internal_offset_mv(ioff),
        .comp_enable(en), .integ_limit(lim), .target_pos(tgt), .pos_offset(poff),
        .obj_wr(wr), .obj_rd(rd), .obj_index(idx), .obj_subindex(sub), .obj_wdata(wd),
        .obj_rdata(rdat), .obj_err(err), .vin_mv(vin), .vin_valid(vv), .dz_out(dz),
        .dz_valid(dv), .comp_value(cv), .pos_demand(pd));
    adzpc_host host_u (.core_clk(core_clk), .obj_rdata(rdat), .obj_err(err), .obj_wr(wr),
        .obj_rd(rd), .obj_index(idx), .obj_subindex(sub), .obj_wdata(wd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0d exp %0d", $time, got, exp);
        end
    endtask : chk
    // reads expect d back, writes check only the error flag and, when no error is expected, record d as the threshold
    task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d, input logic x);
        host_u.xfer(w, a[23:8], a[7:0], d, rv, e);
        chk(32'(e), 32'(x));
        if (!w) chk(32'(rv), 32'(d));
        if (w && !x) thr = d;
    endtask : acc
    task automatic smp(input logic signed [15:0] c);
        int v;
        v = (int'(c) - int'(off)) * ADZPC_FS_MV / ADZPC_FS_LSB - int'(ioff);
        if (!(en && thr != 0 && v - dz_m <= thr && dz_m - v <= thr)) dz_m = v;
        @(negedge core_clk);
        {code, sv} = {c, 1'b1};
        @(negedge core_clk);
        sv = 1'b0;
        chk(vv ? vin : 'x, v);
        @(negedge core_clk);
        chk(dv ? dz : 'x, dz_m);
    endtask : smp
    task automatic settle(input int c);
        repeat (3) @(negedge core_clk);
        chk(cv, c);
        chk(pd, tgt + poff + c);
    endtask : settle
    task automatic t_regs();
        acc(1'b0, A_CNT, 16'(ADZPC_ENTRY_COUNT), 1'b0);
        acc(1'b0, A_DZ, ADZPC_DEADZONE_RST, 1'b0);
        acc(1'b1, A_DZ, 16'hFFFF, 1'b0);
        acc(1'b0, A_DZ, 16'hFFFF, 1'b0);
        acc(1'b1, A_DZ, 16'h0064, 1'b0);
        acc(1'b1, A_CNT, 16'h0005, 1'b1);
        acc(1'b0, 24'h431701, 16'h0000, 1'b1);
        $display("regs done");
    endtask : t_regs
    task automatic t_scale();
        smp(16'sh6CF0);
        ioff = 16'sh0DAC;
        smp(16'sh6CF0);
        {ioff, off} = {16'sh0000, 16'sh1057};
        smp(16'sh1057);
        off = 16'sh0000;
        $display("scale done");
    endtask : t_scale
    task automatic t_dz();
        en = 1'b1;
        smp(16'sh0AE5);
        smp(16'sh0B54);
        smp(16'sh0BFC);
        smp(16'sh0BFF);
        smp(16'shF51B);
        en = 1'b0;
        smp(16'sh0B54);
        smp(16'sh0B60);
        en = 1'b1;
        acc(1'b1, A_DZ, 16'h0000, 1'b0);
        smp(16'sh0B54);
        smp(16'sh0B58);
        $display("dead zone done");
    endtask : t_dz
    task automatic t_int();
        {en, lim} = {1'b0, 31'(LIMIT)};
        settle(0);
        en = 1'b1;
        repeat (2) smp(16'sh0AE5);
        settle(LIMIT);
        repeat (3) smp(16'shF51B);
        settle(-LIMIT);
        en = 1'b0;
        settle(0);
        $display("integral done");
    endtask : t_int
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        t_regs();
        t_scale();
        t_dz();
        t_int();
        report_and_stop();
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule : adzpc_core_bench
